// ==== rtl/exec_pkg.sv ====
// Purpose: Shared constants and types for the instruction execution slice
// Assumes: 8-bit data path, 15-bit program counter, 7-bit page latch
// Notes: Summary of operation follows
// Summary of operation
// - Computed call pushes the address after the current one onto the stack
// - Computed call loads PC low byte from W, high bits from page latch
// - Computed call takes two instruction cycles
// - Clear-file writes zero to the addressed file register and sets zero flag
// - Clear-W loads zero into the working register and sets zero flag
// - Clear-watchdog zeroes both watchdog counter and its prescaler
// - Clear-watchdog sets the timeout and powerdown status bits to one
// - Complement inverts the file register and updates zero flag
// - Destination bit 0 sends result to W, 1 back to file register
// - Decrement subtracts one, routes by destination bit, updates zero flag
// - Decrement-skip on zero result discards next instruction, two cycles
// - Decrement-skip with non-zero result lets next instruction run
// - Absolute branch loads its 11-bit operand into PC bits 10 to 0
// - Absolute branch fills PC bits 14 to 11 from page latch bits 6 to 3
// - Absolute branch takes two instruction cycles
package exec_pkg;

    localparam int PC_W = 15;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int TARGET_W = 11;
    localparam int PAGE_W = 7;

    // Field positions of the page latch used by the absolute branch
    localparam int BRANCH_PAGE_MSB = 6;
    localparam int BRANCH_PAGE_LSB = 3;

    // Reset values
    localparam logic [14:0] PC_RESET = 15'h0000;
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;
    localparam logic STATUS_RESET = 1'b1;
    localparam logic [7:0] CLEAR_VALUE = 8'h00;

    // Timing counts in instruction cycles
    localparam int SHORT_OP_CYCLES = 1;
    localparam int LONG_OP_CYCLES = 2;

    typedef enum logic [3:0] {
        op_nop,
        call_via_working_reg,
        clear_file_reg,
        clear_working_reg,
        clear_watchdog,
        complement_file_reg,
        decrement_file_reg,
        decrement_skip_zero,
        absolute_branch
    } op_e;

    typedef struct packed {
        op_e op;
        logic [6:0] file_addr;
        logic dest_file;
        logic [10:0] target;
    } instr_s;

    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } file_wr_s;

    typedef struct packed {
        logic push;
        logic [14:0] addr;
    } stack_push_s;

endpackage : exec_pkg

// ==== rtl/watchdog_counter.sv ====
// Purpose: Watchdog prescaler and counter with synchronous clear
// Assumes: Runs on the core instruction clock
// Notes: Timeout is a one-cycle pulse when both stages wrap
`timescale 1ns/1ps
module watchdog_counter #(
    parameter int PRE_W = 8,
    parameter int CNT_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clear,
    output logic timeout
);

    logic [PRE_W-1:0] pre_reg;
    logic [PRE_W-1:0] pre_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic timeout_reg;
    logic timeout_next;

    generate
        if (PRE_W < 1 || CNT_W < 1) begin : g_bad_width
            $error("watchdog widths must be at least one");
        end
    endgenerate

    // Prescaler feeds counter; clear beats counting so a late kick is kept
    always_comb begin
        pre_next = pre_reg + PRE_W'(1);
        cnt_next = cnt_reg;
        timeout_next = 1'b0;
        if (&pre_reg) begin
            cnt_next = cnt_reg + CNT_W'(1);
            timeout_next = &cnt_reg;
        end
        if (clear) begin
            pre_next = '0;
            cnt_next = '0;
            timeout_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= '0;
            cnt_reg <= '0;
            timeout_reg <= 1'b0;
        end else begin
            pre_reg <= pre_next;
            cnt_reg <= cnt_next;
            timeout_reg <= timeout_next;
        end
    end

    assign timeout = timeout_reg;

    a_dog_cleared: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        clear |=> (pre_reg == '0) && (cnt_reg == '0) && !timeout)
        else $error("watchdog not cleared");

endmodule : watchdog_counter

// ==== rtl/exec_slice.sv ====
// Purpose: Executes calls, clears, complement, decrements and branches
// Assumes: File register read is combinational on the same clock
// Notes: A two-cycle op holds instr_ready low for its second cycle
`timescale 1ns/1ps
module exec_slice #(
    parameter int DOG_PRE_W = 8,
    parameter int DOG_CNT_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input exec_pkg::instr_s instr,
    output logic instr_ready,
    output logic [6:0] file_raddr,
    input wire logic [7:0] file_rdata,
    input wire logic [6:0] pc_page_latch,
    input wire logic sleep_entry,
    output exec_pkg::file_wr_s file_wr,
    output exec_pkg::stack_push_s stack_push,
    output logic [14:0] pc,
    output logic [7:0] working_reg,
    output logic zero_flag,
    output logic timeout_status_bit,
    output logic powerdown_status_bit,
    output logic discard
);
    import exec_pkg::*;

    typedef enum logic [1:0] {
        st_exec,
        st_branch_flush,
        st_skip_flush
    } state_e;

    state_e state_reg;
    state_e state_next;
    logic [14:0] pc_reg;
    logic [14:0] pc_next;
    logic [7:0] w_reg;
    logic [7:0] w_next;
    logic z_reg;
    logic z_next;
    logic to_reg;
    logic to_next;
    logic pwrdn_reg;
    logic pwrdn_next;
    file_wr_s fw_reg;
    file_wr_s fw_next;
    stack_push_s push_reg;
    stack_push_s push_next;
    logic dog_clear;
    logic dog_timeout;
    logic accept;
    logic [7:0] dec_val;
    logic [7:0] comp_val;
    logic [14:0] pc_inc;

    watchdog_counter #(
        .PRE_W(DOG_PRE_W),
        .CNT_W(DOG_CNT_W)
    ) u_watchdog (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clear(dog_clear),
        .timeout(dog_timeout)
    );

    // New instruction is taken only in the execute state
    assign instr_ready = (state_reg == st_exec);
    assign accept = instr_valid && instr_ready;
    assign file_raddr = instr.file_addr;
    assign dec_val = file_rdata - 8'h01;
    assign comp_val = ~file_rdata;
    assign pc_inc = pc_reg + 15'h0001;

    // Decode and execute; results are registered one edge later
    always_comb begin
        state_next = st_exec;
        pc_next = pc_reg;
        w_next = w_reg;
        z_next = z_reg;
        fw_next = '{we: 1'b0, addr: instr.file_addr, data: CLEAR_VALUE};
        push_next = '{push: 1'b0, addr: pc_inc};
        dog_clear = 1'b0;
        to_next = dog_timeout ? 1'b0 : to_reg;
        pwrdn_next = sleep_entry ? 1'b0 : pwrdn_reg;
        unique case (state_reg)
            st_exec: begin
                if (accept) begin
                    pc_next = pc_inc;
                    unique case (instr.op)
                        op_nop: begin
                        end
                        call_via_working_reg: begin
                            push_next.push = 1'b1;
                            pc_next = {pc_page_latch, w_reg};
                            state_next = st_branch_flush;
                        end
                        clear_file_reg: begin
                            fw_next.we = 1'b1;
                            z_next = 1'b1;
                        end
                        clear_working_reg: begin
                            w_next = CLEAR_VALUE;
                            z_next = 1'b1;
                        end
                        clear_watchdog: begin
                            dog_clear = 1'b1;
                            to_next = 1'b1;
                            pwrdn_next = 1'b1;
                        end
                        complement_file_reg: begin
                            z_next = (comp_val == 8'h00);
                            if (instr.dest_file) begin
                                fw_next.we = 1'b1;
                                fw_next.data = comp_val;
                            end else begin
                                w_next = comp_val;
                            end
                        end
                        decrement_file_reg, decrement_skip_zero: begin
                            // Only the plain decrement touches the zero flag
                            if (instr.op == decrement_file_reg) begin
                                z_next = (dec_val == 8'h00);
                            end
                            if (instr.dest_file) begin
                                fw_next.we = 1'b1;
                                fw_next.data = dec_val;
                            end else begin
                                w_next = dec_val;
                            end
                            if (instr.op == decrement_skip_zero &&
                                    dec_val == 8'h00) begin
                                state_next = st_skip_flush;
                            end // else next runs
                        end
                        absolute_branch: begin
                            pc_next = {
                                pc_page_latch[BRANCH_PAGE_MSB:
                                BRANCH_PAGE_LSB], instr.target};
                            state_next = st_branch_flush;
                        end
                    endcase
                end
            end
            st_branch_flush: begin
                // Fetched word is stale; PC already holds the target
                state_next = st_exec;
            end
            st_skip_flush: begin
                // Skipped word executes as a no-op but still advances PC
                pc_next = pc_inc;
                state_next = st_exec;
            end
            default: begin
                state_next = st_exec;
            end
        endcase
    end

    // Register stage; status bits come up set as after power-on
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= st_exec;
            pc_reg <= PC_RESET;
            w_reg <= W_RESET;
            z_reg <= ZERO_RESET;
            to_reg <= STATUS_RESET;
            pwrdn_reg <= STATUS_RESET;
            fw_reg <= '0;
            push_reg <= '0;
        end else begin
            state_reg <= state_next;
            pc_reg <= pc_next;
            w_reg <= w_next;
            z_reg <= z_next;
            to_reg <= to_next;
            pwrdn_reg <= pwrdn_next;
            fw_reg <= fw_next;
            push_reg <= push_next;
        end
    end

    assign pc = pc_reg;
    assign working_reg = w_reg;
    assign zero_flag = z_reg;
    assign timeout_status_bit = to_reg;
    assign powerdown_status_bit = pwrdn_reg;
    assign file_wr = fw_reg;
    assign stack_push = push_reg;
    assign discard = (state_reg != st_exec);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_call_push: assert property (
        accept && instr.op == call_via_working_reg |=> stack_push.push &&
        stack_push.addr == $past(pc_reg) + 15'h0001)
        else $error("call did not push return address");
    a_call_target: assert property (
        accept && instr.op == call_via_working_reg |=>
        pc_reg == {$past(pc_page_latch), $past(w_reg)})
        else $error("call loaded wrong pc");
    a_call_cycles: assert property (
        accept && instr.op == call_via_working_reg |=>
        !instr_ready ##1 instr_ready)
        else $error("call not two cycles");
    a_clear_file: assert property (
        accept && instr.op == clear_file_reg |=> file_wr.we &&
        file_wr.data == 8'h00 && file_wr.addr == $past(instr.file_addr) &&
        zero_flag)
        else $error("clear file wrong");
    a_clear_w: assert property (
        accept && instr.op == clear_working_reg |=>
        working_reg == 8'h00 && zero_flag)
        else $error("clear w wrong");
    a_dog_status: assert property (
        accept && instr.op == clear_watchdog |=>
        timeout_status_bit && powerdown_status_bit)
        else $error("status bits not set");
    a_comp_result: assert property (
        accept && instr.op == complement_file_reg |=>
        zero_flag == ($past(file_rdata) == 8'hff))
        else $error("complement zero flag wrong");
    a_comp_dest: assert property (
        accept && instr.op == complement_file_reg && !instr.dest_file |=>
        working_reg == ~$past(file_rdata) && !file_wr.we)
        else $error("complement to w wrong");
    a_dec_file: assert property (
        accept && instr.op == decrement_file_reg && instr.dest_file |=>
        file_wr.we && file_wr.data == $past(file_rdata) - 8'h01 &&
        zero_flag == ($past(file_rdata) == 8'h01))
        else $error("decrement wrong");
    a_skip_taken: assert property (
        accept && instr.op == decrement_skip_zero &&
        file_rdata == 8'h01 |=> discard ##1 instr_ready &&
        pc_reg == $past(pc_reg, 2) + 15'h0002)
        else $error("skip not two cycles");
    a_skip_none: assert property (
        accept && instr.op == decrement_skip_zero &&
        file_rdata != 8'h01 |=> instr_ready)
        else $error("non-zero decrement skipped");
    a_branch_pc: assert property (
        accept && instr.op == absolute_branch |=> pc_reg ==
        {$past(pc_page_latch[6:3]), $past(instr.target)})
        else $error("branch target wrong");
    a_branch_cycles: assert property (
        accept && instr.op == absolute_branch |=> discard ##1 !discard)
        else $error("branch not two cycles");
    a_single_cycle: assert property (
        accept && (instr.op == clear_file_reg ||
        instr.op == complement_file_reg ||
        instr.op == decrement_file_reg) |=> instr_ready)
        else $error("single-cycle op stalled");

    c_call: cover property (accept && instr.op == call_via_working_reg);
    c_skip: cover property (accept && instr.op == decrement_skip_zero &&
        file_rdata == 8'h01);
    c_branch: cover property (accept && instr.op == absolute_branch);
    c_dog_clear: cover property (accept && instr.op == clear_watchdog);

endmodule : exec_slice

// ==== testbench/tb_cpu_call_clear_branch_exec.sv ====
// Purpose: Self-checking bench for the execution slice
// Assumes: Watchdog stages shrunk to 2 bits each, so it wraps every 16 cycles
// Notes: Driver queues expected results, a watcher pops and compares them
`timescale 1ns/1ps
`define CHK(n, g, e) chk(n, 32'(g), 32'(e))
module tb_cpu_call_clear_branch_exec;
    import exec_pkg::*;

    typedef struct packed {
        logic [14:0] pc;
        logic [7:0] w;
        logic z;
        logic we;
        logic [6:0] wa;
        logic [7:0] wd;
        logic push;
        logic [14:0] pa;
        logic disc;
        logic wdog;
    } note_s;

    logic ref_clk, rst_n, instr_valid, instr_ready, sleep_entry, zero_flag;
    logic timeout_status_bit, powerdown_status_bit, discard, taken;
    instr_s instr;
    file_wr_s file_wr;
    stack_push_s stack_push;
    logic [6:0] file_raddr, page, page_pick;
    logic [7:0] file_rdata, working_reg, exp_w;
    logic [14:0] pc, exp_pc;
    logic exp_z;
    logic [31:0] seed = 32'hcf80;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    note_s q[$];

    exec_slice #(.DOG_PRE_W(2), .DOG_CNT_W(2)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr(instr), .instr_ready(instr_ready), .file_raddr(file_raddr),
        .file_rdata(file_rdata), .pc_page_latch(page),
        .sleep_entry(sleep_entry), .file_wr(file_wr),
        .stack_push(stack_push), .pc(pc), .working_reg(working_reg),
        .zero_flag(zero_flag), .timeout_status_bit(timeout_status_bit),
        .powerdown_status_bit(powerdown_status_bit), .discard(discard)
    );

    // Xorshift source, fixed start so runs repeat
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(string n, logic [31:0] g, logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic tally_and_finish();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    task automatic idle(int n);
        repeat (n) begin
            @(negedge ref_clk);
            instr_valid = 1'b0;
            sleep_entry = 1'b0;
        end
    endtask : idle

    // Offer one instruction, note its expected effect, cover the flush cycle
    task automatic run_op(op_e op, logic [6:0] fa, logic d, logic [10:0] tg,
                          logic [7:0] rd);
        note_s n;
        logic [7:0] r;
        logic skip;
        @(negedge ref_clk);
        instr_valid = 1'b1;
        instr = '{op: op, file_addr: fa, dest_file: d, target: tg};
        file_rdata = rd;
        // Page latch changes only here, off the sampling edge
        page = page_pick;
        #1;
        `CHK("ready", instr_ready, 1'b1);
        `CHK("raddr", file_raddr, fa);
        n = '{pc: exp_pc + 15'h1, w: exp_w, z: exp_z, default: '0};
        skip = 1'b0;
        r = (op == complement_file_reg) ? ~rd : rd - 8'h01;
        case (op)
            call_via_working_reg: begin
                n.push = 1'b1;
                n.pa = exp_pc + 15'h1;
                n.pc = {page, exp_w};
                n.disc = 1'b1;
            end
            clear_file_reg: begin
                n = '{pc: n.pc, w: n.w, z: 1'b1, we: 1'b1, wa: fa,
                      default: '0};
            end
            clear_working_reg: begin
                n.w = 8'h00;
                n.z = 1'b1;
            end
            clear_watchdog: n.wdog = 1'b1;
            complement_file_reg, decrement_file_reg, decrement_skip_zero: begin
                if (d) begin
                    n.we = 1'b1;
                    n.wa = fa;
                    n.wd = r;
                end else begin
                    n.w = r;
                end
                if (op != decrement_skip_zero) begin
                    n.z = (r == 8'h00);
                end
                skip = (op == decrement_skip_zero) && (r == 8'h00);
                n.disc = skip;
            end
            absolute_branch: begin
                n.pc = {page[6:3], tg};
                n.disc = 1'b1;
            end
            default: ;
        endcase
        q.push_back(n);
        exp_pc = skip ? n.pc + 15'h1 : n.pc;
        exp_w = n.w;
        exp_z = n.z;
        @(posedge ref_clk);
        if (n.disc) begin
            // Held request in the flush cycle must be refused
            @(negedge ref_clk);
            instr = '{op: op_nop, file_addr: fa, dest_file: d, target: tg};
            #1;
            `CHK("flush ready", instr_ready, 1'b0);
            `CHK("flush discard", discard, 1'b1);
            @(posedge ref_clk);
        end
    endtask : run_op

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Hang guard, well above the 130 or so cycles the tests need
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // Watcher: one result per taken instruction, one cycle later
    always @(posedge ref_clk) taken <= rst_n && instr_valid && instr_ready;
    always @(negedge ref_clk) begin
        note_s n;
        if (taken === 1'b1) begin
            #1;
            if (q.size() == 0) begin
                `CHK("queue", 1'b0, 1'b1);
            end else begin
                n = q.pop_front();
                `CHK("pc", pc, n.pc);
                `CHK("w", working_reg, n.w);
                `CHK("z", zero_flag, n.z);
                `CHK("we", file_wr.we, n.we);
                if (n.we) begin
                    `CHK("waddr", file_wr.addr, n.wa);
                    `CHK("wdata", file_wr.data, n.wd);
                end
                `CHK("push", stack_push.push, n.push);
                if (n.push) `CHK("paddr", stack_push.addr, n.pa);
                `CHK("discard", discard, n.disc);
                if (n.wdog) begin
                    `CHK("to", timeout_status_bit, 1'b1);
                    `CHK("powerdown", powerdown_status_bit, 1'b1);
                end
            end
        end
    end

    initial begin
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr = '0;
        sleep_entry = 1'b0;
        file_rdata = 8'h00;
        page = 7'h00;
        page_pick = 7'h00;
        exp_pc = 15'h0000;
        exp_w = 8'h00;
        exp_z = 1'b0;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        // Watchdog: wrap clears the time-out bit, clear restarts the count
        idle(40);
        `CHK("to wrapped", timeout_status_bit, 1'b0);
        @(negedge ref_clk);
        sleep_entry = 1'b1;
        idle(2);
        `CHK("powerdown slept", powerdown_status_bit, 1'b0);
        run_op(clear_watchdog, 7'h00, 1'b0, 11'h000, 8'h00);
        idle(10);
        `CHK("to held", timeout_status_bit, 1'b1);
        idle(20);
        `CHK("to again", timeout_status_bit, 1'b0);
        // Single-cycle ops back to back, with zero-producing boundaries, then random complement, decrement and skip ops
        page_pick = 7'(rnd());
        run_op(complement_file_reg, 7'h05, 1'b0, 11'h000, 8'(rnd()));
        run_op(clear_working_reg, 7'h00, 1'b0, 11'h000, 8'h00);
        run_op(complement_file_reg, 7'h11, 1'b1, 11'h000, 8'hff);
        run_op(decrement_file_reg, 7'h22, 1'b0, 11'h000, 8'h01);
        run_op(decrement_file_reg, 7'h33, 1'b1, 11'h000, 8'h00);
        run_op(clear_file_reg, 7'h7f, 1'b0, 11'h000, 8'h5a);
        for (int i = 0; i < 16; i++) begin
            run_op(op_e'(4'd5 + 4'(rnd() % 3)), 7'(rnd()), 1'(rnd()),
                   11'h000, 8'(rnd() % 4));
        end
        // Skip taken then not taken, back to back
        run_op(decrement_skip_zero, 7'h40, 1'b1, 11'h000, 8'h01);
        run_op(decrement_skip_zero, 7'h41, 1'b0, 11'h000, 8'h02);
        run_op(clear_file_reg, 7'h00, 1'b1, 11'h000, 8'h00);
        // Calls and branches, top target and random pages
        run_op(complement_file_reg, 7'h07, 1'b0, 11'h000, 8'(rnd()));
        run_op(call_via_working_reg, 7'h00, 1'b0, 11'h000, 8'h00);
        page_pick = 7'(rnd());
        run_op(absolute_branch, 7'h00, 1'b0, 11'h7ff, 8'h00);
        page_pick = 7'(rnd());
        run_op(absolute_branch, 7'h00, 1'b0, 11'(rnd()), 8'h00);
        run_op(call_via_working_reg, 7'h00, 1'b0, 11'h000, 8'h00);
        run_op(op_nop, 7'h00, 1'b0, 11'h000, 8'h00);
        idle(4);
        `CHK("queue empty", q.size(), 0);
        // Mid-run reset: state must return to its power-on values
        @(negedge ref_clk);
        rst_n = 1'b0;
        idle(2);
        rst_n = 1'b1;
        exp_pc = 15'h0000;
        exp_w = 8'h00;
        exp_z = 1'b0;
        `CHK("reset pc", pc, 15'h0000);
        `CHK("reset to", timeout_status_bit, 1'b1);
        `CHK("reset powerdown", powerdown_status_bit, 1'b1);
        run_op(op_nop, 7'h00, 1'b0, 11'h000, 8'h00);
        run_op(clear_working_reg, 7'h00, 1'b0, 11'h000, 8'h00);
        idle(2);
        `CHK("queue drained", q.size(), 0);
        tally_and_finish();
    end
endmodule : tb_cpu_call_clear_branch_exec
